//--- rtl/cpu_accumulator_status_regs.sv
`timescale 1ns/1ps
// What this block does
// (RULE1) Eight-bit read-write primary operand register for arithmetic results.
// (RULE2) Primary operand register at address e0, bit-addressable, resets to zero.
// (RULE3) Eight-bit read-write secondary operand register at f0, resets to zero.
// (RULE4) Status word at address d0, bit-addressable, all bits reset to zero.
// (RULE5) Carry flag follows carry or borrow of last arithmetic operation.
// (RULE6) Nibble carry flag follows carry into or borrow from upper nibble.
// (RULE7) Bits 5 and 1 are user flags changed only by firmware writes.
// (RULE8) Bank select bits 4:3 choose the working register bank.
// (RULE9) Bank values 0 to 3 map registers to bases 00, 08, 10, 18.
// (RULE10) Exception flag set on signed overflow of add, addc or subb.
// (RULE11) Exception flag set when multiply product exceeds 255.
// (RULE12) Exception flag set when divide has a zero divisor; the code needs secondary_operand_reg and alu_secondary_data both zero.
// (RULE13) Those five instructions clear the exception flag otherwise.
// (RULE14) Parity bit is read-only, odd count of ones in primary register.
// (RULE15) Parity writes ignored; parity tracks primary register at every change.
// (RULE16) Single-bit writes change only the addressed bit.
module cpu_accumulator_status_regs (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sfr_wr,
  input wire logic sfr_bit_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [2:0] sfr_bit_sel,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_bit_wdata,
  input wire logic [7:0] sfr_raddr,
  input wire logic alu_wr_primary,
  input wire logic [7:0] alu_primary_data,
  input wire logic alu_wr_secondary,
  input wire logic [7:0] alu_secondary_data,
  input wire logic flag_load,
  input wire core_regs_pkg::arith_op_t flag_op,
  input wire logic alu_carry,
  input wire logic alu_nibble_carry,
  input wire logic alu_signed_overflow,
  input wire logic [7:0] mul_high_byte,
  input wire logic [2:0] reg_index,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  output logic [7:0] primary_operand_reg,
  output logic [7:0] secondary_operand_reg,
  output logic [7:0] status_word_reg,
  output logic [1:0] bank_select,
  output logic [7:0] working_reg_addr
);
  logic [7:0] next_primary;
  logic [7:0] next_secondary;
  logic [7:0] next_status;
  logic [7:0] next_rdata;
  logic next_hit;
  logic [7:0] next_working_addr;
  logic [7:0] status_core;
  logic [7:0] primary_after_sfr;
  logic [7:0] secondary_after_sfr;
  logic [7:0] status_after_sfr;
  logic exception_value;

  flag_update_if fu ();

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  function automatic logic [7:0] write_byte(input logic [7:0] old_value,
                                            input logic byte_wr,
                                            input logic bit_wr,
                                            input logic [2:0] bit_sel,
                                            input logic [7:0] wdata,
                                            input logic bit_value);
    logic [7:0] result;
    result = old_value;
    if (byte_wr) begin
      result = wdata;
    end else if (bit_wr) begin
      result[bit_sel] = bit_value; // RULE16
    end
    return result;
  endfunction : write_byte

  function automatic logic [7:0] with_parity(input logic [7:0] status, input logic [7:0] acc);
    logic [7:0] result;
    result = status;
    result[core_regs_pkg::parity_bit] = ^acc; // RULE14 RULE15
    return result;
  endfunction : with_parity

  // ----------------------------------------
  // Register update
  // ----------------------------------------
  always_comb begin
    primary_after_sfr = write_byte(primary_operand_reg,
                                   sfr_wr && sfr_addr == core_regs_pkg::primary_operand_addr,
                                   sfr_bit_wr && sfr_addr == core_regs_pkg::primary_operand_addr,
                                   sfr_bit_sel, sfr_wdata, sfr_bit_wdata); // RULE1 RULE2
    secondary_after_sfr = write_byte(secondary_operand_reg,
                                     sfr_wr && sfr_addr == core_regs_pkg::secondary_operand_addr,
                                     sfr_bit_wr &&
                                     sfr_addr == core_regs_pkg::secondary_operand_addr,
                                     sfr_bit_sel, sfr_wdata, sfr_bit_wdata); // RULE3
    status_after_sfr = write_byte(status_word_reg,
                                  sfr_wr && sfr_addr == core_regs_pkg::status_word_addr,
                                  sfr_bit_wr && sfr_addr == core_regs_pkg::status_word_addr,
                                  sfr_bit_sel, sfr_wdata, sfr_bit_wdata); // RULE4 RULE7 RULE8
    next_primary = alu_wr_primary ? alu_primary_data : primary_after_sfr;
    next_secondary = alu_wr_secondary ? alu_secondary_data : secondary_after_sfr;
    case (flag_op)
      core_regs_pkg::op_mul: exception_value = mul_high_byte != 8'h00; // RULE11
      core_regs_pkg::op_div: exception_value = alu_secondary_data == 8'h00 &&
                                               secondary_operand_reg == 8'h00; // RULE12
      default: exception_value = alu_signed_overflow; // RULE10
    endcase
  end

  always_comb begin
    fu.status_in = status_after_sfr;
    fu.flag_load = flag_load;
    fu.flag_carry = alu_carry;
    fu.flag_nibble = alu_nibble_carry;
    fu.flag_overflow = exception_value;
    fu.op = flag_op;
    status_core = fu.status_out;
    next_status = with_parity(status_core, next_primary); // RULE15
  end

  flag_merge u_flag_merge (
    .fu(fu.merge)
  );

  // ----------------------------------------
  // Read port and bank address
  // ----------------------------------------
  always_comb begin
    next_hit = 1'b1;
    case (sfr_raddr)
      core_regs_pkg::primary_operand_addr: next_rdata = next_primary;
      core_regs_pkg::secondary_operand_addr: next_rdata = next_secondary;
      core_regs_pkg::status_word_addr: next_rdata = next_status;
      default: begin
        next_rdata = 8'h00;
        next_hit = 1'b0;
      end
    endcase
    next_working_addr = {3'h0, next_status[core_regs_pkg::bank_hi_bit:core_regs_pkg::bank_lo_bit],
                         reg_index}; // RULE8 RULE9
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      primary_operand_reg <= core_regs_pkg::reg_reset_value; // RULE2
      secondary_operand_reg <= core_regs_pkg::reg_reset_value; // RULE3
      status_word_reg <= core_regs_pkg::reg_reset_value; // RULE4
      bank_select <= 2'h0;
      working_reg_addr <= 8'h00;
      sfr_rdata <= 8'h00;
      sfr_hit <= 1'b0;
    end else begin
      primary_operand_reg <= next_primary;
      secondary_operand_reg <= next_secondary;
      status_word_reg <= next_status;
      bank_select <= next_status[core_regs_pkg::bank_hi_bit:core_regs_pkg::bank_lo_bit];
      working_reg_addr <= next_working_addr;
      sfr_rdata <= next_rdata;
      sfr_hit <= next_hit;
    end
  end
endmodule : cpu_accumulator_status_regs

//--- rtl/core_regs_pkg.sv
package core_regs_pkg;
  localparam logic [7:0] status_word_addr = 8'hd0;
  localparam logic [7:0] primary_operand_addr = 8'he0;
  localparam logic [7:0] secondary_operand_addr = 8'hf0;
  localparam logic [7:0] reg_reset_value = 8'h00;
  localparam int carry_bit = 7;
  localparam int nibble_carry_bit = 6;
  localparam int user_zero_bit = 5;
  localparam int bank_hi_bit = 4;
  localparam int bank_lo_bit = 3;
  localparam int exception_bit = 2;
  localparam int user_one_bit = 1;
  localparam int parity_bit = 0;
  localparam logic [7:0] bank_stride = 8'h08;

  typedef enum logic [2:0] {
    op_none,
    op_add,
    op_addc,
    op_subb,
    op_mul,
    op_div,
    op_other
  } arith_op_t;
endpackage : core_regs_pkg

//--- rtl/flag_update_if.sv
`timescale 1ns/1ps
interface flag_update_if;
  logic [7:0] status_in;
  logic [7:0] status_out;
  logic flag_load;
  logic flag_carry;
  logic flag_nibble;
  logic flag_overflow;
  core_regs_pkg::arith_op_t op;

  modport ctl (output flag_load, flag_carry, flag_nibble, flag_overflow, op, status_in,
               input status_out);
  modport merge (input flag_load, flag_carry, flag_nibble, flag_overflow, op, status_in,
                 output status_out);
endinterface : flag_update_if

//--- rtl/flag_merge.sv
`timescale 1ns/1ps
module flag_merge (
  flag_update_if.merge fu
);
  // ----------------------------------------
  // Arithmetic flag merge
  // ----------------------------------------
  always_comb begin
    fu.status_out = fu.status_in;
    if (fu.flag_load) begin
      fu.status_out[core_regs_pkg::carry_bit] = fu.flag_carry; // RULE5
      fu.status_out[core_regs_pkg::nibble_carry_bit] = fu.flag_nibble; // RULE6
      case (fu.op)
        core_regs_pkg::op_add,
        core_regs_pkg::op_addc,
        core_regs_pkg::op_subb,
        core_regs_pkg::op_mul,
        core_regs_pkg::op_div: begin
          fu.status_out[core_regs_pkg::exception_bit] = fu.flag_overflow; // RULE10 RULE13
        end
        default: begin
        end
      endcase
    end
  end
endmodule : flag_merge

//--- verif/cpu_acc_checker.sv
`timescale 1ns/1ps
module cpu_acc_checker (
  input wire logic mclk, rst_b, sfr_wr, sfr_bit_wr, flag_load, alu_wr_primary,
  input wire logic alu_carry, alu_nibble_carry, alu_signed_overflow,
  input wire core_regs_pkg::arith_op_t flag_op,
  input wire logic [7:0] mul_high_byte, alu_primary_data, primary_operand_reg,
  input wire logic [7:0] status_word_reg, working_reg_addr,
  input wire logic [2:0] reg_index,
  input wire logic [1:0] bank_select
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_parity_track: assert property (status_word_reg[0] == ^primary_operand_reg)
    else $error("bad parity");
  a_bank_field: assert property (bank_select == status_word_reg[4:3])
    else $error("bad bank");
  a_acc_load: assert property (
    alu_wr_primary |=> primary_operand_reg == $past(alu_primary_data)) else $error("bad load");
  a_carry_load: assert property (
    flag_load |=> status_word_reg[7:6] == {$past(alu_carry), $past(alu_nibble_carry)})
    else $error("bad carry");
  a_mul_ovf: assert property (
    flag_load && flag_op == core_regs_pkg::op_mul |=>
    status_word_reg[2] == ($past(mul_high_byte) != 8'h00)) else $error("bad mul flag");
  a_add_ovf: assert property (
    flag_load && flag_op == core_regs_pkg::op_add |=>
    status_word_reg[2] == $past(alu_signed_overflow)) else $error("bad add flag");
  a_user_hold: assert property (
    !sfr_wr && !sfr_bit_wr |=> $stable(status_word_reg[5:3]) && $stable(status_word_reg[1]))
    else $error("user bits moved");
  a_bank_map: assert property (
    $stable(bank_select) |-> working_reg_addr == {3'h0, bank_select, $past(reg_index)})
    else $error("bad bank address");
endmodule : cpu_acc_checker
bind cpu_accumulator_status_regs cpu_acc_checker chk (.*);

//--- verif/alu_side.sv
`timescale 1ns/1ps
module alu_side (
  input wire logic mclk, en,
  output logic alu_wr_primary, alu_wr_secondary, flag_load,
  output logic alu_carry, alu_nibble_carry, alu_signed_overflow,
  output logic [7:0] alu_primary_data, alu_secondary_data, mul_high_byte,
  output core_regs_pkg::arith_op_t flag_op
);
  // Zero operands are favoured so that divide by zero and small products occur often.
  initial begin
    forever begin
      alu_wr_primary = en === 1'b1 && $urandom % 4 == 0;
      alu_wr_secondary = en === 1'b1 && $urandom % 4 == 0;
      flag_load = en === 1'b1 && $urandom % 2 == 0;
      {alu_carry, alu_nibble_carry, alu_signed_overflow} = 3'($urandom);
      alu_primary_data = 8'($urandom);
      alu_secondary_data = $urandom % 2 ? 8'h00 : 8'($urandom);
      mul_high_byte = $urandom % 2 ? 8'h00 : 8'($urandom);
      flag_op = core_regs_pkg::arith_op_t'($urandom % 7);
      @(posedge mclk);
      #1;
    end
  end
endmodule : alu_side

//--- verif/cpu_accumulator_status_regs_tb_top.sv
`timescale 1ns/1ps
module cpu_accumulator_status_regs_tb_top;
  logic mclk = 1'b0, rst_b = 1'b0, en = 1'b0;
  logic sfr_wr = 1'b0, sfr_bit_wr = 1'b0, sfr_bit_wdata = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_raddr = 8'h00;
  logic [2:0] sfr_bit_sel = 3'h0, reg_index = 3'h0, ri;
  logic alu_wr_primary, alu_wr_secondary, flag_load, sfr_hit;
  logic alu_carry, alu_nibble_carry, alu_signed_overflow;
  logic [7:0] alu_primary_data, alu_secondary_data, mul_high_byte, sfr_rdata;
  logic [7:0] primary_operand_reg, secondary_operand_reg, status_word_reg, working_reg_addr;
  logic [7:0] d, r, ra, ob, ea = 8'h00, eb = 8'h00, ep = 8'h00;
  logic [7:0] tbl [4] = '{8'hd0, 8'he0, 8'hf0, 8'hd1};
  // Corner cases: all ones into the status word, odd primary, zero secondary, plain read.
  logic [16:0] corner [4] = '{{1'b1, 8'hd0, 8'hff}, {1'b1, 8'he0, 8'h01},
                              {1'b1, 8'hf0, 8'h00}, {1'b0, 8'he0, 8'h00}};
  logic [1:0] bank_select, pb;
  core_regs_pkg::arith_op_t flag_op;
  int mismatches = 0, samples_checked = 0;
  always #2.5 mclk = ~mclk;
  alu_side alu (.*);
  cpu_accumulator_status_regs dut (.*);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  // Reference copy of the three registers, advanced at each edge from the inputs.
  always @(posedge mclk) begin
    if (rst_b) begin
      {ob, pb, ri, ra} = {eb, ep[4:3], reg_index, sfr_raddr};
      d = sfr_addr == 8'he0 ? ea : sfr_addr == 8'hf0 ? eb : ep;
      if (sfr_bit_wr) d[sfr_bit_sel] = sfr_bit_wdata;
      if (sfr_wr) d = sfr_wdata;
      if (sfr_wr || sfr_bit_wr) begin
        if (sfr_addr == 8'he0) ea = d;
        if (sfr_addr == 8'hf0) eb = d;
        if (sfr_addr == 8'hd0) ep = d;
      end
      if (alu_wr_primary) ea = alu_primary_data;
      if (alu_wr_secondary) eb = alu_secondary_data;
      if (flag_load) begin
        ep[7:6] = {alu_carry, alu_nibble_carry};
        case (flag_op)
          core_regs_pkg::op_add, core_regs_pkg::op_addc, core_regs_pkg::op_subb: begin
            ep[2] = alu_signed_overflow;
          end
          core_regs_pkg::op_mul: ep[2] = mul_high_byte != 8'h00;
          core_regs_pkg::op_div: ep[2] = alu_secondary_data == 8'h00 && ob == 8'h00;
          default: ;
        endcase
      end
      #2;
      r = ra == 8'he0 ? ea : ra == 8'hf0 ? eb : ra == 8'hd0 ? {ep[7:1], ^ea} : 8'h00;
      chk(primary_operand_reg, ea);
      chk(secondary_operand_reg, eb);
      chk(status_word_reg, {ep[7:1], ^ea});
      chk({6'h0, bank_select}, {6'h0, ep[4:3]});
      if (ep[4:3] == pb) chk(working_reg_addr, {3'h0, pb, ri});
      chk(sfr_rdata, r);
      chk({7'h0, sfr_hit}, {7'h0, ra inside {8'hd0, 8'he0, 8'hf0}});
    end
  end
  initial begin
    void'($urandom(6));
    repeat (4) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    chk(primary_operand_reg | secondary_operand_reg | status_word_reg, 8'h00);
    en = 1'b1;
    repeat (3000) begin
      @(posedge mclk);
      #1;
      sfr_wr = $urandom % 4 == 0;
      sfr_bit_wr = $urandom % 3 == 0;
      sfr_addr = tbl[$urandom % 4];
      sfr_raddr = tbl[$urandom % 4];
      sfr_wdata = 8'($urandom);
      {sfr_bit_sel, sfr_bit_wdata, reg_index} = 7'($urandom);
    end
    en = 1'b0;
    foreach (corner[i]) begin
      @(posedge mclk);
      #1;
      sfr_bit_wr = 1'b0;
      {sfr_wr, sfr_addr, sfr_wdata} = corner[i];
      sfr_raddr = corner[i][15:8];
    end
    @(posedge mclk);
    #1;
    sfr_wr = 1'b0;
    repeat (2) @(posedge mclk);
    #3;
    finish_test;
  end
endmodule : cpu_accumulator_status_regs_tb_top
